// [logic/iopld_pkg.sv]
`default_nettype none
package iopld_pkg;
    // Width of one port; direction is selected per bit.
    localparam int IOPLD_WIDTH = 8;
    // Latch and direction after reset: latch low, every bit an input.
    localparam logic [7:0] IOPLD_LATCH_RESET = 8'h00;
    localparam logic [7:0] IOPLD_DIR_RESET = 8'h00;
    // Value returned when the write-only direction address is read.
    localparam logic [7:0] IOPLD_DIR_READ_VALUE = 8'h00;
    // Register selects on the internal bus.
    localparam logic IOPLD_SEL_PORT = 1'b0;
    localparam logic IOPLD_SEL_DIR = 1'b1;
endpackage
`default_nettype wire

// [logic/iopld_port.sv]
`timescale 1ns/10ps
`default_nettype none
// Function
// R01: Input bits read the sampled pin level.
// R02: Port writes always update the latch.
// R03: Output bits read latch or peripheral output.
// R04: Output bits drive the latch onto pins.
// R05: Direction register reads never return its contents.
// R06: Reset leaves every bit in input mode.
// R07: Master sets direction only by full-byte stores.
// R08: Pull-up acts only on input bits.
// R09: Direction one is output, zero is input.
module iopld_port #(
    parameter int WIDTH = iopld_pkg::IOPLD_WIDTH,
    parameter logic [7:0] PERIPH_READ_SEL = 8'h00
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic bus_sel,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [WIDTH-1:0] bus_wdata,
    output logic [WIDTH-1:0] bus_rdata,
    input wire logic [WIDTH-1:0] pullup_ctrl,
    input wire logic [WIDTH-1:0] periph_out,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] pullup_en
);
    import iopld_pkg::*;

    // Hazard for software: a read-modify-write of the port register copies
    // the pin level of every input bit, and the selected source of every
    // output bit, back into the latch. The latch of an input bit can thus
    // change although the program meant to touch another bit. Nothing here
    // prevents that; it is a property of the port, not a fault.
    // The direction register cannot be read back, so a store to it must
    // carry the whole byte. A direction read returns a fixed value instead.
    // Read data is registered: it appears one cycle after the read strobe
    // and stands until the next read, so the bus may sample it late.

    // Bus-side state, the pin synchroniser and the next values.
    // The read mux output is plain logic and is only seen through rdata.
    logic [WIDTH-1:0] latch;
    logic [WIDTH-1:0] dir;
    logic [WIDTH-1:0] pin_meta;
    logic [WIDTH-1:0] pin_sync;
    logic [WIDTH-1:0] rdata;
    logic [WIDTH-1:0] next_latch;
    logic [WIDTH-1:0] next_dir;
    logic [WIDTH-1:0] next_rdata;
    logic [WIDTH-1:0] read_port;

    // Next latch and direction; the direction is only ever replaced whole.
    // A port write lands in the latch even for input bits, so software can
    // preload the level that a bit drives once it is switched to output.
    always_comb begin
        next_latch = latch;
        next_dir = dir;
        if (bus_wr && bus_sel == IOPLD_SEL_PORT) begin
            next_latch = bus_wdata; // [R02]
        end
        if (bus_wr && bus_sel == IOPLD_SEL_DIR) begin
            next_dir = bus_wdata; // [R07] [R09]
        end
    end

    // Port read mux: pins for inputs, latch or peripheral for outputs.
    // The choice between latch and peripheral is fixed per bit at build
    // time, because software has no way to select it at run time.
    always_comb begin
        read_port = '0;
        for (int i = 0; i < WIDTH; i++) begin
            if (!dir[i]) begin
                read_port[i] = pin_sync[i]; // [R01]
            end else if (PERIPH_READ_SEL[i]) begin
                read_port[i] = periph_out[i]; // [R03]
            end else begin
                read_port[i] = latch[i]; // [R03]
            end
        end
    end

    // Read data is registered; direction reads give a fixed value.
    // A write and a read in one cycle see the state before the write.
    always_comb begin
        next_rdata = rdata;
        if (bus_rd) begin
            if (bus_sel == IOPLD_SEL_DIR) begin
                next_rdata = IOPLD_DIR_READ_VALUE[WIDTH-1:0]; // [R05]
            end else begin
                next_rdata = read_port;
            end
        end
    end

    // The bus-side state changes only on a bus strobe, so it is kept apart
    // from the pin synchroniser, which follows the pins on every edge.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            latch <= IOPLD_LATCH_RESET[WIDTH-1:0];
            dir <= IOPLD_DIR_RESET[WIDTH-1:0]; // [R06]
            rdata <= '0;
        end else begin
            latch <= next_latch;
            dir <= next_dir;
            rdata <= next_rdata;
        end
    end

    // Pins are asynchronous to mclk, so each bit passes two flip-flops.
    // Only the second stage feeds the read mux; the first may be metastable.
    // The price is two cycles of latency on every input read.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    // Pin drive and pull-up gating follow the direction bits.
    // The latch is always on pin_out; pin_oe decides whether it reaches
    // the pad, so an input bit keeps its latch ready for a later switch.
    assign pin_out = latch; // [R04]
    assign pin_oe = dir; // [R04] [R09]
    // A driven pin never carries a pull-up, whatever software asked for.
    assign pullup_en = pullup_ctrl & ~dir; // [R08]
    assign bus_rdata = rdata;

    // Checks on the state that reset leaves behind.
    reset_input_a: assert property (@(posedge mclk) // [R06]
        $rose(reset_n) |-> pin_oe == '0)
        else $error("Port not in input mode after reset.");

    reset_latch_a: assert property (@(posedge mclk) // [R06]
        $rose(reset_n) |-> pin_out == IOPLD_LATCH_RESET[WIDTH-1:0])
        else $error("Latch not cleared by reset.");

    reset_pullup_a: assert property (@(posedge mclk) // [R08]
        $rose(reset_n) |-> pullup_en == pullup_ctrl)
        else $error("Pull-ups not free after reset.");

    // Checks on writes: latch and direction change only when addressed.
    // Each write is seen one edge later, as the registers take it.
    port_write_a: assert property (@(posedge mclk) // [R02]
        disable iff (!reset_n)
        bus_wr && bus_sel == IOPLD_SEL_PORT |=> latch == $past(bus_wdata))
        else $error("Port write did not update latch.");

    latch_hold_a: assert property (@(posedge mclk) // [R02]
        disable iff (!reset_n)
        !(bus_wr && bus_sel == IOPLD_SEL_PORT) |=> $stable(pin_out))
        else $error("Latch changed without a port write.");

    dir_write_a: assert property (@(posedge mclk) // [R09]
        disable iff (!reset_n)
        bus_wr && bus_sel == IOPLD_SEL_DIR |=> pin_oe == $past(bus_wdata))
        else $error("Direction write not applied.");

    dir_hold_a: assert property (@(posedge mclk) // [R06]
        disable iff (!reset_n)
        !(bus_wr && bus_sel == IOPLD_SEL_DIR) |=> $stable(pin_oe))
        else $error("Direction changed without write.");

    // Checks on reads. A read within two cycles of reset release sees the
    // cleared synchroniser rather than the pin; software must wait.
    dir_read_a: assert property (@(posedge mclk) // [R05]
        disable iff (!reset_n)
        bus_rd && bus_sel == IOPLD_SEL_DIR
        |=> bus_rdata == IOPLD_DIR_READ_VALUE[WIDTH-1:0])
        else $error("Direction read leaked contents.");

    rdata_hold_a: assert property (@(posedge mclk) // [R05]
        disable iff (!reset_n)
        !bus_rd |=> $stable(bus_rdata))
        else $error("Read data changed without a read.");

    input_read_a: assert property (@(posedge mclk) // [R01]
        disable iff (!reset_n)
        bus_rd && bus_sel == IOPLD_SEL_PORT && dir == '0
        |=> bus_rdata == $past(pin_in, 3))
        else $error("Input read not the pin level.");

    input_bits_a: assert property (@(posedge mclk) // [R01]
        disable iff (!reset_n)
        bus_rd && bus_sel == IOPLD_SEL_PORT
        |=> (bus_rdata & ~$past(dir)) == ($past(pin_in, 3) & ~$past(dir)))
        else $error("Input bit of a mixed port read wrong.");

    output_read_a: assert property (@(posedge mclk) // [R03]
        disable iff (!reset_n)
        bus_rd && bus_sel == IOPLD_SEL_PORT && dir == '1
        |=> bus_rdata == $past((latch & ~PERIPH_READ_SEL[WIDTH-1:0])
            | (periph_out & PERIPH_READ_SEL[WIDTH-1:0])))
        else $error("Output read source wrong.");

    output_bits_a: assert property (@(posedge mclk) // [R03]
        disable iff (!reset_n)
        bus_rd && bus_sel == IOPLD_SEL_PORT
        |=> (bus_rdata & $past(dir)) == ($past(dir)
            & $past((latch & ~PERIPH_READ_SEL[WIDTH-1:0])
            | (periph_out & PERIPH_READ_SEL[WIDTH-1:0]))))
        else $error("Output bit of a mixed port read wrong.");

    // Checks on the pads: drive and pull-up never overlap.
    // A pull-up fighting a driven pin would only waste current.
    pin_drive_a: assert property (@(posedge mclk) // [R04]
        disable iff (!reset_n)
        ((pin_out & pin_oe) == (latch & dir)))
        else $error("Output pin not latch value.");

    pullup_gate_a: assert property (@(posedge mclk) // [R08]
        disable iff (!reset_n)
        (pullup_en & pin_oe) == '0)
        else $error("Pull-up on output bit.");

    pullup_pass_a: assert property (@(posedge mclk) // [R08]
        disable iff (!reset_n)
        (pullup_en & ~pin_oe) == (pullup_ctrl & ~pin_oe))
        else $error("Pull-up request lost on input bit.");
endmodule
`default_nettype wire

// [tb/iopld_board.sv]
`timescale 1ns/10ps
`default_nettype none
// Board side of the port: driven pins loop back, others see the board.
module iopld_board (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext,
    output logic [7:0] pin_in
);
    // An enabled bit shows the latch value on its pin.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule
`default_nettype wire

// [tb/tb_io_port_latch_direction.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_io_port_latch_direction;
    import iopld_pkg::*;
    logic mclk = 0, reset_n = 0, sel = 0, wr = 0, rd = 0;
    logic [7:0] wd = 8'h00, pu = 8'h5A, per = 8'hC3, ext = 8'h00;
    logic [7:0] rdat, pout, poe, puen, pin;
    int err_total = 0, checks = 0;
    // Rows: direction, latch, board level, expected port read.
    logic [7:0] rows [4][4] = '{'{8'h00, 8'hA5, 8'h3C, 8'h3C},
        '{8'hFF, 8'hA5, 8'h3C, 8'hE5}, '{8'h0F, 8'h96, 8'hF0, 8'hF6},
        '{8'hF0, 8'h5A, 8'h0F, 8'hDF}};
    // The top two bits read the peripheral output when driven.
    iopld_port #(.PERIPH_READ_SEL(8'hC0)) DUT (.mclk(mclk),
        .reset_n(reset_n), .bus_sel(sel),
        .bus_wr(wr), .bus_rd(rd), .bus_wdata(wd), .bus_rdata(rdat),
        .pullup_ctrl(pu), .periph_out(per), .pin_in(pin),
        .pin_out(pout), .pin_oe(poe), .pullup_en(puen));
    iopld_board board (.pin_out(pout), .pin_oe(poe), .ext(ext),
        .pin_in(pin));
    // Free-running system clock.
    always #10 mclk = ~mclk;
    // Whole-byte stores and reads only, one strobe cycle each.
    task automatic op(input logic s, input logic w, input logic [7:0] d);
        @(posedge mclk);
        #1 sel = s;
        wr = w;
        rd = ~w;
        wd = d;
        @(posedge mclk);
        #1 wr = 0;
        rd = 0;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        if (err_total == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Cuts a hang short well after the tests should have ended.
    initial begin
        #100000;
        err_total++;
        give_verdict();
    end
    // Main sequence: reset, table rows, then the awkward cases.
    initial begin
        repeat (2) @(posedge mclk);
        #1 reset_n = 1;
        chk(poe, IOPLD_DIR_RESET);
        for (int i = 0; i < 4; i++) begin
            ext = rows[i][2];
            op(1'b0, 1'b1, rows[i][1]);
            op(1'b1, 1'b1, rows[i][0]);
            repeat (4) @(posedge mclk);
            op(1'b0, 1'b0, 8'h00);
            chk(rdat, rows[i][3]);
            chk(pout, rows[i][1]);
            chk(poe, rows[i][0]);
            chk(puen, pu & ~rows[i][0]);
        end
        op(1'b1, 1'b0, 8'h00);
        chk(rdat, IOPLD_DIR_READ_VALUE);
        // A second reset in mid-run must drop every bit back to input.
        @(posedge mclk);
        #1 reset_n = 0;
        @(posedge mclk);
        #1 chk(poe, IOPLD_DIR_RESET);
        chk(pout, IOPLD_LATCH_RESET);
        chk(puen, pu);
        reset_n = 1;
        repeat (3) @(posedge mclk);
        #1 chk(poe, IOPLD_DIR_RESET);
        op(1'b0, 1'b1, 8'h3C);
        chk(pout, 8'h3C);
        chk(poe, IOPLD_DIR_RESET);
        give_verdict();
    end
endmodule
`default_nettype wire
